// ==== sais_pkg.sv ====
// Purpose: constants and types for the serial audio input selector
// Assumes: control fields arrive as plain ports, no register bus
// Notes: format field packs framing mode and word length
package sais_pkg;
	localparam int SEL_HI = 7;
	localparam int SEL_LO = 6;
	localparam int MUX_EN_BIT = 8;
	localparam int CTRL2_W = 9;
	localparam logic [CTRL2_W-1:0] CTRL2_RESET = 9'h000;
	localparam int FMT_MODE_HI = 1;
	localparam int FMT_MODE_LO = 0;
	localparam int FMT_LEN_HI = 3;
	localparam int FMT_LEN_LO = 2;
	localparam int WORD_W = 24;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] LEN_24 = 6'h18;
	localparam logic [CNT_W-1:0] LEN_20 = 6'h14;
	localparam logic [CNT_W-1:0] LEN_16 = 6'h10;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
	localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
	localparam logic [1:0] CODE_I2S = 2'h0;
	localparam logic [1:0] CODE_LJ = 2'h1;
	localparam logic [1:0] CODE_RJ = 2'h2;
	localparam logic [1:0] CODE_DSP = 2'h3;
	localparam logic [1:0] LCODE_20 = 2'h1;
	localparam logic [1:0] LCODE_16 = 2'h2;
	localparam int ZERO_W = 11;
	localparam logic [ZERO_W-1:0] ZERO_FRAMES = 11'h400;
	localparam int GROUPS = 3;
	localparam int PIN_W = 10;
	localparam int PIN_AUX = 9;
	localparam int TAPS = 4;

	typedef enum logic [3:0] {
		MODE_I2S = 4'h1,
		MODE_LJ = 4'h2,
		MODE_RJ = 4'h4,
		MODE_DSP = 4'h8
	} sais_mode_t;

	typedef struct packed {
		logic data;
		logic bclk;
		logic lrclk;
	} sais_group_t;

	typedef struct packed {
		logic [WORD_W-1:0] left;
		logic [WORD_W-1:0] right;
		logic [WORD_W-1:0] auxLeft;
		logic [WORD_W-1:0] auxRight;
	} sais_frame_t;
endpackage : sais_pkg

// ==== sais_top.sv ====
// Purpose: serial audio input selector, receiver, silence flag and capture output
// Assumes: all serial pins are asynchronous to clk and are oversampled by it
// Notes: bit clock must stay well below a quarter of clk for edges to be seen
`timescale 1ns/1ps
module sais_top (
	input wire logic clk,
	input wire logic clkEn,
	input wire logic resetn,
	input wire logic serial_in_data_a,
	input wire logic serial_in_data_b,
	input wire logic serial_in_data_c,
	input wire logic bit_clock_in_a,
	input wire logic bit_clock_in_b,
	input wire logic bit_clock_in_c,
	input wire logic frame_clock_in_a,
	input wire logic frame_clock_in_b,
	input wire logic frame_clock_in_c,
	input wire logic auxiliary_serial_in,
	input wire logic [3:0] formatCtrl,
	input wire logic [sais_pkg::CTRL2_W-1:0] selectCtrl,
	input wire logic auxEnable,
	input wire logic [sais_pkg::TAPS-1:0][sais_pkg::WORD_W-1:0] tapWord,
	input wire logic [sais_pkg::TAPS-1:0] tapStrobe,
	input wire logic [1:0] captureSelLeft,
	input wire logic [1:0] captureSelRight,
	output logic muxed_serial_data_out,
	output logic muxed_bit_clock_out,
	output logic muxed_frame_clock_out,
	output logic silence_indicator,
	output logic capture_serial_out,
	output sais_pkg::sais_frame_t rxFrame,
	output logic rxFrameValid,
	output logic [sais_pkg::TAPS-1:0][sais_pkg::WORD_W-1:0] captureWords
);
	function automatic logic [sais_pkg::CNT_W-1:0] wordLen(input logic [3:0] fmt);
		logic [1:0] code;
		code = fmt[sais_pkg::FMT_LEN_HI:sais_pkg::FMT_LEN_LO];
		if (code == sais_pkg::LCODE_20)
			return sais_pkg::LEN_20;
		else if (code == sais_pkg::LCODE_16)
			return sais_pkg::LEN_16;
		return sais_pkg::LEN_24;
	endfunction : wordLen

	function automatic sais_pkg::sais_mode_t decodeMode(input logic [3:0] fmt);
		logic [1:0] code;
		code = fmt[sais_pkg::FMT_MODE_HI:sais_pkg::FMT_MODE_LO];
		unique case (code)
			sais_pkg::CODE_I2S: return sais_pkg::MODE_I2S;
			sais_pkg::CODE_LJ: return sais_pkg::MODE_LJ;
			sais_pkg::CODE_RJ: return sais_pkg::MODE_RJ;
			sais_pkg::CODE_DSP: return sais_pkg::MODE_DSP;
		endcase
	endfunction : decodeMode

	// keeps the low len bits, MSB-aligned, so the sign bit lands on bit 23
	function automatic logic [sais_pkg::WORD_W-1:0] alignWord(
		input logic [sais_pkg::WORD_W-1:0] raw,
		input logic [sais_pkg::CNT_W-1:0] len
	);
		return raw << (sais_pkg::LEN_24 - len);
	endfunction : alignWord

	logic [sais_pkg::CTRL2_W-1:0] selCfg_q;
	logic [sais_pkg::PIN_W-1:0] pinRaw;
	logic [sais_pkg::PIN_W-1:0] sync1_q, sync2_q, sync3_q, pinF_q;
	logic [1:0] gIdx;
	sais_pkg::sais_group_t grp, muxOut_q;
	sais_pkg::sais_mode_t mode;
	logic [sais_pkg::CNT_W-1:0] len;
	logic bclkPrev_q, lrcAtRise_q, lrcAtFall_q;
	logic bclkRise, bclkFall, lrcEdge, txEdge;

	// a one-cycle-old copy; select is steady across reset release
	always_ff @(posedge clk)
		if (!resetn)
			selCfg_q <= sais_pkg::CTRL2_RESET;
		else if (clkEn)
			selCfg_q <= selectCtrl;

	assign pinRaw = {auxiliary_serial_in,
		serial_in_data_c, bit_clock_in_c, frame_clock_in_c,
		serial_in_data_b, bit_clock_in_b, frame_clock_in_b,
		serial_in_data_a, bit_clock_in_a, frame_clock_in_a};

	always_ff @(posedge clk)
		if (!resetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end
		else if (clkEn)
		begin
			sync1_q <= pinRaw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end

	// a change is accepted only once the two later stages agree
	for (genvar i = 0; i < sais_pkg::PIN_W; i++)
	begin : g_filt
		always_ff @(posedge clk)
			if (!resetn)
				pinF_q[i] <= 1'b0;
			else if (clkEn && sync2_q[i] == sync3_q[i])
				pinF_q[i] <= sync3_q[i];
	end

	// code 11 is not a real source; fall back to group a
	assign gIdx = (selCfg_q[sais_pkg::SEL_HI:sais_pkg::SEL_LO] == 2'h3) ? 2'h0 :
		selCfg_q[sais_pkg::SEL_HI:sais_pkg::SEL_LO];
	assign grp = sais_pkg::sais_group_t'(pinF_q[3*gIdx +: 3]);

	always_ff @(posedge clk)
		if (!resetn)
			muxOut_q <= '0;
		else if (clkEn)
			muxOut_q <= selCfg_q[sais_pkg::MUX_EN_BIT] ? grp : '0;

	assign muxed_serial_data_out = muxOut_q.data;
	assign muxed_bit_clock_out = muxOut_q.bclk;
	assign muxed_frame_clock_out = muxOut_q.lrclk;

	assign mode = decodeMode(formatCtrl);
	assign len = wordLen(formatCtrl);
	assign bclkRise = grp.bclk & ~bclkPrev_q;
	assign bclkFall = ~grp.bclk & bclkPrev_q;
	assign lrcEdge = grp.lrclk != lrcAtRise_q;
	assign txEdge = grp.lrclk != lrcAtFall_q;

	always_ff @(posedge clk)
		if (!resetn)
		begin
			bclkPrev_q <= 1'b0;
			lrcAtRise_q <= 1'b0;
			lrcAtFall_q <= 1'b0;
		end
		else if (clkEn)
		begin
			bclkPrev_q <= grp.bclk;
			if (bclkRise)
				lrcAtRise_q <= grp.lrclk;
			if (bclkFall)
				lrcAtFall_q <= grp.lrclk;
		end

	// receive path: shift on every rising bit clock, count bits to find the word end (right-justified ends at the frame clock edge)
	logic [sais_pkg::WORD_W-1:0] rxSh_q, auxSh_q, shNext, auxNext;
	logic [sais_pkg::CNT_W-1:0] rxCnt_q, cntD, cntInc;
	logic rxLeft_q, leftD, emit, emitLeft, useOld;
	logic [sais_pkg::WORD_W-1:0] word, auxWord, leftHold_q, auxLeftHold_q;

	assign shNext = {rxSh_q[sais_pkg::WORD_W-2:0], grp.data};
	assign auxNext = {auxSh_q[sais_pkg::WORD_W-2:0], pinF_q[sais_pkg::PIN_AUX]};
	assign cntInc = rxCnt_q + sais_pkg::CNT_ONE;

	always_comb
	begin
		emit = 1'b0;
		emitLeft = rxLeft_q;
		useOld = 1'b0;
		cntD = rxCnt_q;
		leftD = rxLeft_q;
		if (bclkRise)
			unique case (mode)
				sais_pkg::MODE_I2S, sais_pkg::MODE_LJ:
					if (lrcEdge)
					begin
						// inter-IC-sound delays the MSB by one bit clock
						cntD = (mode == sais_pkg::MODE_LJ) ? sais_pkg::CNT_ONE : '0;
						leftD = (mode == sais_pkg::MODE_LJ) ? grp.lrclk : ~grp.lrclk;
					end
					else if (rxCnt_q < len)
					begin
						cntD = cntInc;
						emit = (cntInc == len);
					end
				sais_pkg::MODE_RJ:
					if (lrcEdge)
					begin
						// the word just before the frame clock edge belongs to the old half
						emit = 1'b1;
						useOld = 1'b1;
						emitLeft = lrcAtRise_q;
					end
				sais_pkg::MODE_DSP:
					if (grp.lrclk && !lrcAtRise_q)
					begin
						cntD = sais_pkg::CNT_ONE;
						leftD = 1'b1;
					end
					else if (rxCnt_q < len)
					begin
						cntD = cntInc;
						emit = (cntInc == len);
						if (emit && rxLeft_q)
						begin
							cntD = '0;
							leftD = 1'b0;
						end
					end
			endcase
	end

	assign word = alignWord(useOld ? rxSh_q : shNext, len);
	assign auxWord = auxEnable ? alignWord(useOld ? auxSh_q : auxNext, len) : '0;

	always_ff @(posedge clk)
		if (!resetn)
		begin
			rxSh_q <= '0;
			auxSh_q <= '0;
			rxCnt_q <= sais_pkg::CNT_MAX;
			rxLeft_q <= 1'b0;
		end
		else if (clkEn && bclkRise)
		begin
			rxSh_q <= shNext;
			auxSh_q <= auxNext;
			rxCnt_q <= cntD;
			rxLeft_q <= leftD;
		end

	always_ff @(posedge clk)
		if (!resetn)
		begin
			leftHold_q <= '0;
			auxLeftHold_q <= '0;
			rxFrame <= '0;
			rxFrameValid <= 1'b0;
		end
		else if (clkEn)
		begin
			rxFrameValid <= emit && !emitLeft;
			if (emit && emitLeft)
			begin
				leftHold_q <= word;
				auxLeftHold_q <= auxWord;
			end
			if (emit && !emitLeft)
				rxFrame <= '{left: leftHold_q, right: word,
					auxLeft: auxLeftHold_q, auxRight: auxWord};
		end

	// silence detect over whole frames on both inputs
	logic [sais_pkg::ZERO_W-1:0] zeroCnt_q;
	logic nonzero;
	assign nonzero = emit && (word != '0 || auxWord != '0);

	always_ff @(posedge clk)
		if (!resetn)
		begin
			zeroCnt_q <= '0;
			silence_indicator <= 1'b0;
		end
		else if (clkEn)
		begin
			if (nonzero)
			begin
				zeroCnt_q <= '0;
				silence_indicator <= 1'b0;
			end
			else if (emit && !emitLeft && zeroCnt_q != sais_pkg::ZERO_FRAMES)
			begin
				zeroCnt_q <= zeroCnt_q + 11'h001;
				silence_indicator <= (zeroCnt_q + 11'h001) == sais_pkg::ZERO_FRAMES;
			end
		end

	// four independent capture registers loaded from the processing taps
	logic [sais_pkg::TAPS-1:0][sais_pkg::WORD_W-1:0] capReg_q;
	for (genvar t = 0; t < sais_pkg::TAPS; t++)
	begin : g_cap
		always_ff @(posedge clk)
			if (!resetn)
				capReg_q[t] <= '0;
			else if (clkEn && tapStrobe[t])
				capReg_q[t] <= tapWord[t];
	end
	assign captureWords = capReg_q;

	// capture transmit: same framing as the receive side, launched on falling bit clock
	logic [sais_pkg::WORD_W-1:0] txSh_q, txWord;
	logic [sais_pkg::CNT_W-1:0] txCnt_q, txPos_q, halfLen_q, curPos;
	logic txPend_q, txLoad, txGap;

	assign curPos = txEdge ? '0 : txPos_q;

	always_comb
	begin
		txLoad = 1'b0;
		txGap = 1'b0;
		txWord = capReg_q[grp.lrclk ? captureSelLeft : captureSelRight];
		unique case (mode)
			sais_pkg::MODE_I2S:
			begin
				txWord = capReg_q[grp.lrclk ? captureSelRight : captureSelLeft];
				txLoad = txEdge;
				txGap = txEdge;
			end
			sais_pkg::MODE_LJ: txLoad = txEdge;
			sais_pkg::MODE_RJ: txLoad = (curPos == halfLen_q - len);
			sais_pkg::MODE_DSP:
				if (grp.lrclk && !lrcAtFall_q)
				begin
					txLoad = 1'b1;
					txWord = capReg_q[captureSelLeft];
				end
				else if (txPend_q && txCnt_q == len)
				begin
					txLoad = 1'b1;
					txWord = capReg_q[captureSelRight];
				end
		endcase
	end

	always_ff @(posedge clk)
		if (!resetn)
		begin
			txSh_q <= '0;
			capture_serial_out <= 1'b0;
			txCnt_q <= '0;
			txPos_q <= '0;
			halfLen_q <= '0;
			txPend_q <= 1'b0;
		end
		else if (clkEn && bclkFall)
		begin
			if (txEdge)
				halfLen_q <= txPos_q;
			txPos_q <= (curPos == sais_pkg::CNT_MAX) ? curPos : curPos + sais_pkg::CNT_ONE;
			if (txGap)
			begin
				capture_serial_out <= 1'b0;
				txSh_q <= txWord;
			end
			else if (txLoad)
			begin
				capture_serial_out <= txWord[sais_pkg::WORD_W-1];
				txSh_q <= txWord << 1;
				txCnt_q <= sais_pkg::CNT_ONE;
				txPend_q <= (mode == sais_pkg::MODE_DSP) && grp.lrclk && !lrcAtFall_q;
			end
			else
			begin
				capture_serial_out <= txSh_q[sais_pkg::WORD_W-1];
				txSh_q <= txSh_q << 1;
				if (txCnt_q != sais_pkg::CNT_MAX)
					txCnt_q <= txCnt_q + sais_pkg::CNT_ONE;
			end
		end

	sequence sNonzeroSample;
		clkEn && nonzero;
	endsequence
	sequence sI2sTxEdge;
		clkEn && bclkFall && mode == sais_pkg::MODE_I2S && txEdge;
	endsequence

	a_reset_select: assert property (@(posedge clk) !resetn |=> selCfg_q == '0)
		else $error("select config not cleared by reset");
	a_mux_off_zero: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && !selCfg_q[sais_pkg::MUX_EN_BIT] |=>
		!muxed_serial_data_out && !muxed_bit_clock_out && !muxed_frame_clock_out)
		else $error("mux outputs driven while disabled");
	a_mux_route_b: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && selCfg_q[sais_pkg::MUX_EN_BIT] &&
		selCfg_q[sais_pkg::SEL_HI:sais_pkg::SEL_LO] == 2'h1 |=>
		muxed_serial_data_out == $past(pinF_q[5]))
		else $error("select 01 did not route group b data");
	a_sel_fallback: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && selCfg_q[sais_pkg::MUX_EN_BIT] &&
		selCfg_q[sais_pkg::SEL_HI:sais_pkg::SEL_LO] == 2'h3 |=>
		muxed_frame_clock_out == $past(pinF_q[0]))
		else $error("select 11 did not fall back to group a");
	a_silence_run: assert property (@(posedge clk) disable iff (!resetn)
		$rose(silence_indicator) |-> zeroCnt_q == sais_pkg::ZERO_FRAMES)
		else $error("silence flag rose before the full zero run");
	a_silence_drop: assert property (@(posedge clk) disable iff (!resetn)
		sNonzeroSample |=> !silence_indicator && zeroCnt_q == '0)
		else $error("nonzero sample did not clear silence");
	a_cap_load: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && tapStrobe[2] |=> captureWords[2] == $past(tapWord[2]))
		else $error("capture register missed its tap");
	a_aux_gated: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && emit && !emitLeft && !auxEnable |=> rxFrame.auxRight == '0 ##0 rxFrameValid)
		else $error("aux word leaked while aux input disabled");
	a_i2s_gap: assert property (@(posedge clk) disable iff (!resetn)
		sI2sTxEdge |=> !capture_serial_out)
		else $error("capture output skipped the one-bit delay");
	a_rx_count: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && bclkRise && !lrcEdge && mode == sais_pkg::MODE_LJ && rxCnt_q < len |=>
		rxCnt_q == $past(rxCnt_q) + sais_pkg::CNT_ONE)
		else $error("bit counter did not advance");
endmodule : sais_top

// ==== sais_source.sv ====
// Purpose: behavioural serial audio source for the selector bench
// Assumes: 125 ns bit clock, 32 bit slots per half frame
// Notes: bit clock stands low between bursts; released data lines show the inverse level
`timescale 1ns/1ps
module sais_source (
	output sais_pkg::sais_group_t grp,
	output logic aux
);
	initial
	begin
		grp = '0;
		aux = 1'b0;
	end

	// frame clock and data move on the falling bit clock so they are steady at the rise
	task automatic put_bit(input logic lr, input logic d, input logic a);
		grp.bclk = 1'b0;
		grp.lrclk = lr;
		grp.data = d;
		aux = a;
		#62.5;
		grp.bclk = 1'b1;
		#62.5;
	endtask : put_bit

	task automatic send(input logic [1:0] mode, input int len, input int n,
		input logic [23:0] l, input logic [23:0] r, input logic [23:0] al,
		input logic [23:0] ar);
		int idx;
		logic h;
		logic d;
		logic a;
		for (int f = -1; f <= n; f++)
		begin
			for (int p = (f < 0) ? 60 : 0; p < ((f == n) ? 2 : 64); p++)
			begin
				case (mode)
					2'h0: idx = p % 32 - 1;
					2'h1: idx = p % 32;
					2'h2: idx = p % 32 - (32 - len);
					default: idx = (p < len) ? p : p - len;
				endcase
				h = (mode == 2'h3) ? (p >= len) : (p >= 32);
				d = 1'b0;
				a = 1'b0;
				if (f >= 0 && f < n && idx >= 0 && idx < len)
				begin
					d = h ? r[23 - idx] : l[23 - idx];
					a = h ? ar[23 - idx] : al[23 - idx];
				end
				put_bit((mode == 2'h3) ? (p == 0) : ((p < 32) ^ (mode == 2'h0)), d, a);
			end
		end
		grp.bclk = 1'b0;
		grp.data = ~grp.data;
		aux = ~aux;
	endtask : send
endmodule : sais_source

// ==== tb_top.sv ====
// Purpose: self-checking bench for the serial audio input selector
// Assumes: clkEn high but for one freeze check; 1024 silent frames do not fit the run
// Notes: unselected groups carry inverted data so a wrong mux choice shows in the words
`timescale 1ns/1ps
module tb_top;
	logic clk;
	logic resetn;
	logic clkEn;
	logic [3:0] formatCtrl;
	logic [sais_pkg::CTRL2_W-1:0] selectCtrl;
	logic auxEnable;
	logic [sais_pkg::TAPS-1:0][sais_pkg::WORD_W-1:0] tapWord;
	logic [sais_pkg::TAPS-1:0] tapStrobe;
	logic [1:0] captureSelLeft;
	logic [1:0] captureSelRight;
	logic muxData;
	logic muxBclk;
	logic muxLrclk;
	logic silence;
	logic capOut;
	logic rxValid;
	sais_pkg::sais_frame_t rxFrame;
	logic [sais_pkg::TAPS-1:0][sais_pkg::WORD_W-1:0] captureWords;
	sais_pkg::sais_group_t src;
	sais_pkg::sais_group_t alt;
	logic auxPin;
	int srcSel;
	int failures;
	int compares;
	int cycles;
	logic [95:0] lastFrame;
	logic [95:0] expFrame;
	logic [65:0] capBits;

	assign alt = '{data: ~src.data, bclk: src.bclk, lrclk: src.lrclk};

	sais_source sais_source_inst (.grp(src), .aux(auxPin));

	sais_top sais_top_inst (.clk(clk), .clkEn(clkEn), .resetn(resetn),
		.serial_in_data_a(srcSel == 0 ? src.data : alt.data),
		.serial_in_data_b(srcSel == 1 ? src.data : alt.data),
		.serial_in_data_c(srcSel == 2 ? src.data : alt.data),
		.bit_clock_in_a(src.bclk), .bit_clock_in_b(src.bclk), .bit_clock_in_c(src.bclk),
		.frame_clock_in_a(src.lrclk), .frame_clock_in_b(src.lrclk),
		.frame_clock_in_c(src.lrclk), .auxiliary_serial_in(auxPin),
		.formatCtrl(formatCtrl), .selectCtrl(selectCtrl), .auxEnable(auxEnable),
		.tapWord(tapWord), .tapStrobe(tapStrobe), .captureSelLeft(captureSelLeft),
		.captureSelRight(captureSelRight), .muxed_serial_data_out(muxData),
		.muxed_bit_clock_out(muxBclk), .muxed_frame_clock_out(muxLrclk),
		.silence_indicator(silence), .capture_serial_out(capOut), .rxFrame(rxFrame),
		.rxFrameValid(rxValid), .captureWords(captureWords));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (rxValid === 1'b1)
			lastFrame <= rxFrame;
		cycles++;
		if (cycles == 80000)
		begin
			failures++;
			wrap_up();
		end
	end

	// sample well after the rise, once the output has moved past the falling edge
	always @(posedge src.bclk)
	begin
		#30;
		capBits = {capBits[64:0], capOut};
	end

	task automatic check(input logic [95:0] got, input logic [95:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic run(input logic [1:0] mode, input logic [1:0] lc, input int n,
		input logic [23:0] l, input logic [23:0] r, input logic [23:0] al,
		input logic [23:0] ar);
		int len;
		logic [23:0] m;
		len = (lc == 2'h1) ? 20 : (lc == 2'h2) ? 16 : 24;
		m = 24'hffffff << (24 - len);
		@(negedge clk);
		formatCtrl = {lc, mode};
		lastFrame = '0;
		sais_source_inst.send(mode, len, n, l, r, al, ar);
		repeat (12) @(negedge clk);
		expFrame = {l & m, r & m, auxEnable ? al & m : 24'h0, auxEnable ? ar & m : 24'h0};
	endtask : run

	task automatic wrap_up();
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	initial
	begin
		resetn = 1'b0;
		clkEn = 1'b1;
		formatCtrl = 4'h1;
		selectCtrl = '0;
		auxEnable = 1'b1;
		tapWord = '0;
		tapStrobe = '0;
		captureSelLeft = 2'h2;
		captureSelRight = 2'h3;
		srcSel = 0;
		failures = 0;
		compares = 0;
		cycles = 0;
		capBits = '0;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		check({muxData, muxBclk, muxLrclk, silence}, 96'h0);
		run(2'h1, 2'h0, 2, 24'h9a5c3e, 24'h6b1d2f, 24'h123456, 24'hfedcba);
		check(lastFrame, expFrame);
		for (int md = 0; md < 4; md++)
		begin
			for (int lc = 0; lc < 3; lc++)
			begin
				run(md[1:0], lc[1:0], 2, 24'ha5c3e7 ^ md[23:0], 24'h5a3c7e ^ lc[23:0],
					24'h81f00f, 24'h7e0ff1);
				check(lastFrame, expFrame);
			end
		end
		auxEnable = 1'b0;
		run(2'h2, 2'h0, 2, 24'h800001, 24'h7fffff, 24'hffffff, 24'hffffff);
		check(lastFrame, expFrame);
		auxEnable = 1'b1;
		for (int code = 0; code < 4; code++)
		begin
			srcSel = (code == 3) ? 0 : code;
			selectCtrl = {1'b1, code[1:0], 6'h0};
			run(2'h1, 2'h0, 1, 24'hc0ffee ^ code[23:0], 24'h0badf0, 24'h0, 24'h0);
			check(lastFrame, expFrame);
			check({muxData, muxBclk, muxLrclk}, {src.data, src.bclk, src.lrclk});
		end
		selectCtrl = {1'b0, 2'h1, 6'h0};
		srcSel = 1;
		run(2'h0, 2'h0, 1, 24'h0, 24'h0, 24'h0, 24'h0);
		check({muxData, muxBclk, muxLrclk}, 96'h0);
		// back to back strobes, one tap per cycle
		for (int t = 0; t < 4; t++)
		begin
			tapWord[t] = 24'h3c5a00 + t * 24'h111111;
			tapStrobe = 4'h1 << t;
			@(negedge clk);
		end
		tapStrobe = '0;
		@(negedge clk);
		check(captureWords, tapWord);
		// a strobe while the clock enable is low must not load anything
		clkEn = 1'b0;
		tapWord[0] = 24'h5a5a5a;
		tapStrobe = 4'h1;
		@(negedge clk);
		tapStrobe = '0;
		clkEn = 1'b1;
		@(negedge clk);
		check(captureWords[0], 24'h3c5a00);
		run(2'h1, 2'h0, 2, 24'h0, 24'h0, 24'h0, 24'h0);
		check({capBits[65:42], capBits[33:10]}, {tapWord[2], tapWord[3]});
		run(2'h3, 2'h2, 3, 24'h0, 24'h0, 24'h0, 24'h0);
		check(silence, 96'h0);
		wrap_up();
	end
endmodule : tb_top
